/* sfep_pkg.sv */
// shared types and constants for the serial flash erase/program host
package sfep_pkg;

  // clock and serial clock timing
  localparam int unsigned MCLK_NS       = 5;
  localparam int unsigned SCLK_HALF_NS  = 50;
  localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + MCLK_NS - 1) / MCLK_NS;

  // serial frame layout: 4-bit command then 16-bit payload, lsb first
  localparam int unsigned CMD_W      = 4;
  localparam int unsigned PAYLOAD_W  = 16;
  localparam int unsigned FRAME_W    = CMD_W + PAYLOAD_W;
  localparam logic [4:0]  LAST_BIT   = 5'h13;
  localparam logic [4:0]  HOLD_BIT   = 5'h03;

  // four-bit commands
  localparam logic [3:0] CMD_CORE      = 4'h0;
  localparam logic [3:0] CMD_PANEL_CFG = 4'hc;
  localparam logic [3:0] CMD_LOAD_INC2 = 4'hd;
  localparam logic [3:0] CMD_LOAD_PROG = 4'hf;

  // table pointer targets and core instruction templates
  localparam logic [21:0] ERASE_OPT_ADDR  = 22'h3c0004;
  localparam logic [21:0] PANEL_MODE_ADDR = 22'h3c0006;
  localparam logic [15:0] INS_MOVLW       = 16'h0e00;
  localparam logic [15:0] INS_MOVWF_UPPER = 16'h6ef8;
  localparam logic [15:0] INS_MOVWF_HIGH  = 16'h6ef7;
  localparam logic [15:0] INS_MOVWF_LOW   = 16'h6ef6;
  localparam logic [15:0] INS_NOP         = 16'h0000;
  localparam logic [15:0] PANEL_MODE_WORD = 16'h0040;

  // bulk erase options in chip erase order
  localparam logic [7:0] ERASE_BOOT   = 8'h83;
  localparam logic [7:0] ERASE_PANEL1 = 8'h88;
  localparam logic [7:0] ERASE_PANEL2 = 8'h89;
  localparam logic [7:0] ERASE_PANEL3 = 8'h8a;

  // sequence step indices
  localparam logic [4:0] PTR_STEPS   = 5'h06;
  localparam logic [4:0] ROW_PROG_IX = 5'h09;
  localparam logic [4:0] ROW_NOP_IX  = 5'h0a;

  typedef enum logic [1:0] {
    SFEP_OP_CORE,
    SFEP_OP_ERASE,
    SFEP_OP_PANEL,
    SFEP_OP_ROW
  } sfep_op_t;

  // one user request
  typedef struct packed {
    sfep_op_t    op;
    logic [21:0] addr;
    logic [63:0] row;
    logic [3:0]  cmd;
    logic [15:0] payload;
  } sfep_req_t;

  // one serial frame with its timing flags
  typedef struct packed {
    logic [3:0]  cmd;
    logic [15:0] payload;
    logic        hold_prog;
    logic        wait_pre;
    logic        last;
  } sfep_word_t;

endpackage

/* sfep_host.sv */
// host-side sequencer driving the serial clock and data pins of the flash device
// Function
// - boot block erase writes option 83h
// - panel 1 erase writes option 88h next
// - large part: panel 2 erase writes 89h
// - large part: panel 3 erase 8Ah last
// - hold data low erase plus discharge
// - hold fourth clock high for program time
// - hold clock low for discharge time
// - pointer unchanged between loading and programming
// - set panel write mode before programming
// - one row per request, at the address given in the request
`timescale 1ns/1ps
module sfep_host
  import sfep_pkg::*;
#(
  parameter int unsigned PROGRAM_TIME_NS    = 1000000,
  parameter int unsigned DISCHARGE_TIME_NS  = 100000,
  parameter int unsigned BULK_ERASE_TIME_NS = 5000000
) (
  input  wire logic      mclk,
  input  wire logic      resetn,
  input  wire logic      large_variant,
  input  wire logic      req_valid,
  output logic           req_ready,
  input  wire sfep_req_t req,
  output logic           req_done,
  output logic           prog_serial_clk,
  output logic           prog_serial_data_o,
  output logic           prog_serial_data_oe,
  input  wire logic      prog_serial_data_i,
  output logic           data_level
);

  // long intervals become cycle counts; least times round up
  localparam int unsigned PROG_CYC   = (PROGRAM_TIME_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int unsigned DISCH_CYC  = (DISCHARGE_TIME_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int unsigned ERASE_CYC  =
    (BULK_ERASE_TIME_NS + DISCHARGE_TIME_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [31:0] HALF_LD    = 32'(SCLK_HALF_CYC - 1);
  localparam logic [31:0] PROG_LD    = 32'(PROG_CYC - 1);
  localparam logic [31:0] DISCH_LD   = 32'(DISCH_CYC - 1);
  localparam logic [31:0] ERASE_LD   = 32'(ERASE_CYC - 1);

  typedef enum logic [2:0] {
    S_IDLE,
    S_FETCH,
    S_WAIT,
    S_HIGH,
    S_LOW
  } sfep_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // sequence tables
  // core instructions that load the table pointer
  function automatic logic [15:0] ptr_word(input logic [4:0] k, input logic [21:0] a);
    logic [15:0] w;
    w = INS_NOP;
    unique case (k)
      5'h00:   w = INS_MOVLW | {8'h00, 2'b00, a[21:16]};
      5'h01:   w = INS_MOVWF_UPPER;
      5'h02:   w = INS_MOVLW | {8'h00, a[15:8]};
      5'h03:   w = INS_MOVWF_HIGH;
      5'h04:   w = INS_MOVLW | {8'h00, a[7:0]};
      default: w = INS_MOVWF_LOW;
    endcase
    return w;
  endfunction
  // frame number ix of request r
  function automatic sfep_word_t seq_word(input sfep_req_t r, input logic [4:0] ix,
                                          input logic lg);
    sfep_word_t w;
    logic [4:0] e;
    logic [4:0] k;
    w = '{cmd: CMD_CORE, payload: INS_NOP, hold_prog: 1'b0, wait_pre: 1'b0, last: 1'b0};
    e = 5'((ix - PTR_STEPS) / 3);
    k = 5'((ix - PTR_STEPS) % 3);
    unique case (r.op)
      SFEP_OP_CORE: begin
        w.cmd     = r.cmd;
        w.payload = r.payload;
        w.last    = 1'b1;
      end
      SFEP_OP_ERASE: begin
        if (ix < PTR_STEPS) begin
          w.payload = ptr_word(ix, ERASE_OPT_ADDR);
        end else begin
          // option write, nop, then a zero frame held off by the erase wait
          if (k == 5'h00) begin
            unique case (e)
              5'h00:   w.payload = {8'h00, ERASE_BOOT};
              5'h01:   w.payload = {8'h00, ERASE_PANEL1};
              5'h02:   w.payload = {8'h00, ERASE_PANEL2};
              default: w.payload = {8'h00, ERASE_PANEL3};
            endcase
          end
          w.wait_pre = (k == 5'h02);
          w.last     = (k == 5'h02) && (e == (lg ? 5'h03 : 5'h01));
        end
      end
      SFEP_OP_PANEL: begin
        if (ix < PTR_STEPS) begin
          w.payload = ptr_word(ix, PANEL_MODE_ADDR);
        end else begin
          w.cmd     = CMD_PANEL_CFG;
          w.payload = PANEL_MODE_WORD;
          w.last    = 1'b1;
        end
      end
      SFEP_OP_ROW: begin
        if (ix < PTR_STEPS) begin
          w.payload = ptr_word(ix, r.addr);
        end else if (ix < ROW_NOP_IX) begin
          // low byte goes first on the wire, so it sits in the low half
          w.cmd     = (ix == ROW_PROG_IX) ? CMD_LOAD_PROG : CMD_LOAD_INC2;
          w.payload = r.row[(ix - PTR_STEPS) * 16 +: 16];
        end else begin
          w.hold_prog = 1'b1;
          w.last      = 1'b1;
        end
      end
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser
  logic sync_a;
  logic sync_b;
  logic next_sync_a;
  logic next_sync_b;
  // two flops before anything looks at the data pin
  always_comb begin
    next_sync_a = prog_serial_data_i;
    next_sync_b = sync_a;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
    end
  end
  assign data_level = sync_b;
  ////////////////////////////////////////////////////////////////////////////
  // frame engine: the serial clock is divided down from mclk, so no second domain
  sfep_state_t state;
  sfep_req_t   cur;
  logic [4:0]  idx;
  logic [19:0] shreg;
  logic [4:0]  bitn;
  logic [31:0] cnt;
  logic        hold;
  logic        last;
  logic        sclk;
  logic        prog_serial_data;
  logic        done;
  sfep_state_t next_state;
  sfep_req_t   next_cur;
  logic [4:0]  next_idx;
  logic [19:0] next_shreg;
  logic [4:0]  next_bitn;
  logic [31:0] next_cnt;
  logic        next_hold;
  logic        next_last;
  logic        next_sclk;
  logic        next_prog_serial_data;
  logic        next_done;
  sfep_word_t  fw;
  assign fw = seq_word(cur, idx, large_variant);
  // data changes with the rising clock so it is settled at the device's falling edge
  always_comb begin
    next_state = state;
    next_cur   = cur;
    next_idx   = idx;
    next_shreg = shreg;
    next_bitn  = bitn;
    next_cnt   = (cnt != 32'h0) ? cnt - 32'h1 : cnt;
    next_hold  = hold;
    next_last  = last;
    next_sclk  = sclk;
    next_prog_serial_data = prog_serial_data;
    next_done  = 1'b0;
    unique case (state)
      S_IDLE: begin
        if (req_valid) begin
          next_cur   = req;
          next_idx   = 5'h00;
          next_state = S_FETCH;
        end
      end
      S_FETCH: begin
        next_shreg = {fw.payload, fw.cmd};
        next_hold  = fw.hold_prog;
        next_last  = fw.last;
        next_bitn  = 5'h00;
        if (fw.wait_pre) begin
          next_prog_serial_data = 1'b0;
          next_sclk  = 1'b0;
          next_cnt   = ERASE_LD;
          next_state = S_WAIT;
        end else begin
          next_prog_serial_data = fw.cmd[0];
          next_sclk  = 1'b1;
          next_cnt   = HALF_LD;
          next_state = S_HIGH;
        end
      end
      S_WAIT: begin
        if (cnt == 32'h0) begin
          next_prog_serial_data = shreg[0];
          next_sclk  = 1'b1;
          next_cnt   = HALF_LD;
          next_state = S_HIGH;
        end
      end
      S_HIGH: begin
        if (cnt == 32'h0) begin
          next_sclk  = 1'b0;
          // after the long programming pulse the clock rests low to discharge
          next_cnt   = (hold && bitn == HOLD_BIT) ? DISCH_LD : HALF_LD;
          next_state = S_LOW;
        end
      end
      S_LOW: begin
        if (cnt == 32'h0) begin
          if (bitn == LAST_BIT) begin
            next_idx = idx + 5'h01;
            if (last) begin
              next_done  = 1'b1;
              next_state = S_IDLE;
            end else begin
              next_state = S_FETCH;
            end
          end else begin
            next_bitn  = bitn + 5'h01;
            next_shreg = {1'b0, shreg[19:1]};
            next_prog_serial_data = shreg[1];
            next_sclk  = 1'b1;
            next_cnt   = (hold && bitn + 5'h01 == HOLD_BIT) ? PROG_LD : HALF_LD;
            next_state = S_HIGH;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      cur   <= '0;
      idx   <= 5'h00;
      shreg <= 20'h00000;
      bitn  <= 5'h00;
      cnt   <= 32'h0;
      hold  <= 1'b0;
      last  <= 1'b0;
      sclk  <= 1'b0;
      prog_serial_data <= 1'b0;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      cur   <= next_cur;
      idx   <= next_idx;
      shreg <= next_shreg;
      bitn  <= next_bitn;
      cnt   <= next_cnt;
      hold  <= next_hold;
      last  <= next_last;
      sclk  <= next_sclk;
      prog_serial_data <= next_prog_serial_data;
      done  <= next_done;
    end
  end
  // the host only ever writes, so it owns the data pin whenever it is busy
  assign req_ready           = (state == S_IDLE);
  assign req_done            = done;
  assign prog_serial_clk     = sclk;
  assign prog_serial_data_o  = prog_serial_data;
  assign prog_serial_data_oe = (state != S_IDLE);
  ////////////////////////////////////////////////////////////////////////////
  // checks
  boot_erase_opt_a: assert property (@(posedge mclk) disable iff (!resetn)
    state == S_FETCH && cur.op == SFEP_OP_ERASE && idx == 5'h06
    |=> shreg == {8'h00, ERASE_BOOT, CMD_CORE})
    else $error("boot block erase option wrong");
  panel1_erase_opt_a: assert property (@(posedge mclk) disable iff (!resetn)
    state == S_FETCH && cur.op == SFEP_OP_ERASE && idx == 5'h09
    |=> shreg == {8'h00, ERASE_PANEL1, CMD_CORE})
    else $error("panel 1 erase option wrong");
  panel2_erase_opt_a: assert property (@(posedge mclk) disable iff (!resetn)
    state == S_FETCH && cur.op == SFEP_OP_ERASE && idx == 5'h0c
    |=> shreg[11:4] == ERASE_PANEL2 && large_variant)
    else $error("panel 2 erase on wrong variant");
  panel3_erase_last_a: assert property (@(posedge mclk) disable iff (!resetn)
    state == S_FETCH && cur.op == SFEP_OP_ERASE && idx == 5'h11
    |=> last && state == S_WAIT)
    else $error("panel 3 erase not closing sequence");
  erase_hold_low_a: assert property (@(posedge mclk) disable iff (!resetn)
    state == S_FETCH && fw.wait_pre
    |=> cnt == ERASE_LD && !prog_serial_data && !sclk ##1 (!prog_serial_data && !sclk) [*8])
    else $error("data not held low for erase wait");
  prog_pulse_len_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(sclk) && hold && bitn == HOLD_BIT |-> cnt == PROG_LD)
    else $error("programming pulse length wrong");
  discharge_low_a: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(sclk) && hold && bitn == HOLD_BIT |-> cnt == DISCH_LD ##1 !sclk [*4])
    else $error("discharge interval not held low");
  // nothing but a plain nop may pass between the last load and the programming pulse
  pointer_stable_a: assert property (@(posedge mclk) disable iff (!resetn)
    state == S_FETCH && cur.op == SFEP_OP_ROW && idx == ROW_NOP_IX
    |=> shreg == {INS_NOP, CMD_CORE} && hold && last)
    else $error("pointer touched before programming");
  panel_mode_cmd_a: assert property (@(posedge mclk) disable iff (!resetn)
    state == S_FETCH && cur.op == SFEP_OP_PANEL && idx == PTR_STEPS
    |=> shreg == {PANEL_MODE_WORD, CMD_PANEL_CFG} && last)
    else $error("panel mode command wrong");
  row_start_prog_a: assert property (@(posedge mclk) disable iff (!resetn)
    state == S_FETCH && cur.op == SFEP_OP_ROW && idx == ROW_PROG_IX
    |=> shreg[3:0] == CMD_LOAD_PROG && !last)
    else $error("row not ended by start programming");
  frame_bits_a: assert property (@(posedge mclk) disable iff (!resetn)
    state == S_LOW && cnt == 32'h0 && bitn != LAST_BIT
    |=> state == S_HIGH && sclk && bitn == $past(bitn) + 5'h01)
    else $error("frame shorter than twenty bits");

endmodule

/* sfep_dev_model.sv */
// behavioural model of the flash device on the serial programming pins
`timescale 1ns/1ps
module sfep_dev_model
  import sfep_pkg::*;
#(
  parameter int unsigned PROGRAM_TIME_NS    = 1000,
  parameter int unsigned DISCHARGE_TIME_NS  = 500,
  parameter int unsigned BULK_ERASE_TIME_NS = 2000
) (
  input  wire logic        resetn,
  input  wire logic        sclk,
  input  wire logic        prog_serial_data,
  input  wire logic [21:0] rd_addr,
  output logic      [63:0] rd_row,
  output logic      [19:0] last_frame,
  output logic      [31:0] erase_log,
  output logic      [3:0]  protect,
  output logic      [15:0] panel_mode,
  output int               prog_ns,
  output int               disch_ns,
  output int               viol
);
  logic [7:0]  mem [256];
  logic [7:0]  wbuf [8];
  logic [7:0]  wreg;
  logic [7:0]  erase_opt;
  logic [21:0] table_pointer;
  logic [19:0] shift;
  int          bitcnt;
  logic        erase_arm, prog_arm, progging, disch_pend, frame_chk;
  realtime     t_edge, quiet_until, erase_end;

  // memory and protection are nonvolatile, so serial reset leaves them alone
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    protect    = 4'hf;
    erase_log  = 32'h0;
    panel_mode = 16'h0;
  end

  // byte 0 of the row sits at the lowest address
  always_comb for (int i = 0; i < 8; i++) rd_row[i*8 +: 8] = mem[rd_addr[7:0] + 8'(i)];

  //////////////////////////////////////////////////////////////////////////////
  // bulk erase: effects applied at once, pins must stay quiet for erase+discharge
  task automatic start_erase();
    erase_arm = 1'b0;
    erase_log = {erase_log[23:0], erase_opt};
    case (erase_opt)
      8'h83: begin
        protect[0] = 1'b0;
        foreach (mem[i]) mem[i] = 8'hff;
      end
      8'h88: protect[1] = 1'b0;
      8'h89: protect[2] = 1'b0;
      8'h8a: protect[3] = 1'b0;
      default: ;
    endcase
    erase_end   = $realtime + BULK_ERASE_TIME_NS;
    quiet_until = erase_end + DISCHARGE_TIME_NS;
    frame_chk   = 1'b1;
  endtask

  // one complete frame: core instruction subset and buffer loads
  task automatic exec(input logic [3:0] c, input logic [15:0] p);
    case (c)
      4'h0: begin
        if (p[15:8] == 8'h0e) wreg = p[7:0];
        else if (p == 16'h6ef8) table_pointer[21:16] = wreg[5:0];
        else if (p == 16'h6ef7) table_pointer[15:8] = wreg;
        else if (p == 16'h6ef6) table_pointer[7:0] = wreg;
        else if (p[15:8] == 8'h0 && p[7:0] != 8'h0 && table_pointer == 22'h3c0004) begin
          erase_arm = 1'b1;
          erase_opt = p[7:0];
        end
      end
      4'hc: if (table_pointer == 22'h3c0006) panel_mode = p;
      4'hd, 4'hf: begin
        wbuf[table_pointer[2:0]] = p[7:0];
        wbuf[3'(table_pointer[2:0] + 3'h1)] = p[15:8];
        if (c == 4'hd) table_pointer = table_pointer + 22'h2;
        else prog_arm = 1'b1;
      end
      default: ;
    endcase
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // data is taken on the falling edge; rising edges only time program/discharge
  always @(posedge sclk or negedge sclk or negedge resetn) begin
    if (!resetn) begin
      bitcnt = 0;
      {erase_arm, prog_arm, progging, disch_pend, frame_chk} = 5'h0;
      quiet_until = 0;
      erase_end = 0;
      {prog_ns, disch_ns, viol} = {32'd0, 32'd0, 32'd0};
      last_frame = 20'h0;
    end else if (sclk) begin
      if (disch_pend) begin
        disch_ns = int'($realtime - t_edge);
        if (disch_ns < int'(DISCHARGE_TIME_NS)) viol++;
        disch_pend = 1'b0;
      end
      if (prog_arm && bitcnt == 3) begin
        progging = 1'b1;
        prog_arm = 1'b0;
        t_edge = $realtime;
      end
    end else begin
      if (progging) begin
        prog_ns = int'($realtime - t_edge);
        if (prog_ns < int'(PROGRAM_TIME_NS)) viol++;
        foreach (wbuf[i]) mem[{table_pointer[7:3], 3'(i)}] = wbuf[i];
        progging = 1'b0;
        disch_pend = 1'b1;
        t_edge = $realtime;
      end
      if (prog_serial_data !== 1'b0 && $realtime < quiet_until) viol++;
      if (bitcnt == 0 && frame_chk) begin
        if ($realtime < quiet_until) viol++;
        frame_chk = 1'b0;
      end
      if (bitcnt == 3 && erase_arm) start_erase();
      shift = {prog_serial_data, shift[19:1]};
      bitcnt++;
      if (bitcnt == 20) begin
        bitcnt = 0;
        last_frame = {shift[3:0], shift[19:4]};
        if ($realtime >= erase_end) exec(shift[3:0], shift[19:4]);
      end
    end
  end
endmodule

/* serial_flash_erase_program_tb.sv */
// self-checking bench for the serial flash erase/program host
`timescale 1ns/1ps
module serial_flash_erase_program_tb
  import sfep_pkg::*;
;
  localparam int unsigned P_NS = 1000;
  localparam int unsigned D_NS = 500;
  localparam int unsigned B_NS = 2000;
  typedef struct packed {
    sfep_req_t   rq;
    logic [19:0] frame;
  } sfep_row_t;

  logic        mclk, resetn, large_variant, req_valid, req_ready, req_done;
  logic        sclk, data_o, data_oe, data_level, float_pat;
  sfep_req_t   req;
  wire logic   data_i;
  logic [1:0]  lv;
  logic [21:0] rd_addr;
  logic [63:0] rd_row;
  logic [19:0] last_frame;
  logic [31:0] erase_log;
  logic [3:0]  protect;
  logic [15:0] panel_mode;
  int          prog_ns, disch_ns, viol, bad_count, n_compared, since_rst;
  sfep_row_t   rows [6];

  // released data pin shows a toggling level so a stale value never matches
  assign data_i = data_oe ? data_o : float_pat;
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  sfep_host #(.PROGRAM_TIME_NS(P_NS), .DISCHARGE_TIME_NS(D_NS), .BULK_ERASE_TIME_NS(B_NS)) dut (
    .mclk(mclk), .resetn(resetn), .large_variant(large_variant), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .req_done(req_done), .prog_serial_clk(sclk),
    .prog_serial_data_o(data_o), .prog_serial_data_oe(data_oe),
    .prog_serial_data_i(data_i), .data_level(data_level));

  sfep_dev_model #(.PROGRAM_TIME_NS(P_NS), .DISCHARGE_TIME_NS(D_NS),
    .BULK_ERASE_TIME_NS(B_NS)) model (
    .resetn(resetn), .sclk(sclk), .prog_serial_data(data_i), .rd_addr(rd_addr), .rd_row(rd_row),
    .last_frame(last_frame), .erase_log(erase_log), .protect(protect),
    .panel_mode(panel_mode), .prog_ns(prog_ns), .disch_ns(disch_ns), .viol(viol));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_min(input string what, input int lo, input int got);
    n_compared++;
    if (got < lo) begin
      bad_count++;
      $display("[ERR] %s expected >= %0d seen %0d", what, lo, got);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic sfep_req_t mk(sfep_op_t o, logic [21:0] a, logic [63:0] r,
                                   logic [3:0] c, logic [15:0] p);
    return '{o, a, r, c, p};
  endfunction

  // keep_on holds valid up while busy with a changed payload, which must be ignored
  task automatic send(input sfep_req_t r, input bit keep_on);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #1 n++;
    end
    req = r;
    req_valid = 1'b1;
    @(posedge mclk);
    #1;
    if (keep_on) req.payload = ~req.payload;
    else req_valid = 1'b0;
    if (keep_on) chk("ready while busy", 64'h0, req_ready);
    n = 0;
    while (req_done !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      #1 n++;
    end
    // valid already dropped after the take unless it was held on purpose
    if (keep_on) req_valid = 1'b0;
    if (n >= 20000) begin
      bad_count++;
      print_verdict();
    end
  endtask

  // synchronised pin level lags the wire by two clocks
  always @(posedge mclk) begin
    float_pat <= ~float_pat;
    lv <= {lv[0], data_i};
    if (!resetn) since_rst <= 0;
    else if (since_rst < 4) since_rst <= since_rst + 1;
    else chk("data level", {63'h0, lv[1]}, {63'h0, data_level});
  end

  // watchdog: whole run is about 35k clocks
  initial begin
    #250000;
    bad_count++;
    print_verdict();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, req_valid, large_variant, float_pat} = 4'h0;
    req = '0;
    rd_addr = 22'h0;
    {bad_count, n_compared, since_rst} = {32'd0, 32'd0, 32'd0};
    rows[0] = '{mk(SFEP_OP_CORE, 22'h0, 64'h0, 4'h0, 16'h0e5a), 20'h00e5a};
    rows[1] = '{mk(SFEP_OP_CORE, 22'h0, 64'h0, 4'h0, 16'h6ef6), 20'h06ef6};
    rows[2] = '{mk(SFEP_OP_PANEL, 22'h0, 64'h0, 4'h0, 16'h0), 20'hc0040};
    rows[3] = '{mk(SFEP_OP_ROW, 22'h10, 64'h8877665544332211, 4'h0, 16'h0), 20'h0};
    rows[4] = '{mk(SFEP_OP_ROW, 22'h18, 64'hf0e1d2c3b4a59687, 4'h0, 16'h0), 20'h0};
    rows[5] = '{mk(SFEP_OP_ROW, 22'hf8, 64'h00ff5aa5c33c0f1e, 4'h0, 16'h0), 20'h0};
    repeat (20) @(posedge mclk);
    #1 chk("outputs in reset", 64'h10, {req_ready, req_done, sclk, data_oe, data_o});
    resetn = 1'b1;
    foreach (rows[i]) begin
      send(rows[i].rq, 1'b0);
      chk("last frame", rows[i].frame, last_frame);
      if (rows[i].rq.op == SFEP_OP_ROW) begin
        rd_addr = rows[i].rq.addr;
        #1 chk("row memory", rows[i].rq.row, rd_row);
        chk_min("program high ns", P_NS, prog_ns);
        chk_min("discharge low ns", D_NS, disch_ns);
      end
    end
    chk("panel mode", 64'h40, panel_mode);
    // small part erase, then large part erase with its extra panels
    send(mk(SFEP_OP_ERASE, 22'h0, 64'h0, 4'h0, 16'h0), 1'b0);
    chk("erase options", 64'h8388, erase_log);
    chk("protect after erase", 64'hc, protect);
    rd_addr = 22'h10;
    #1 chk("boot block erased", {64{1'b1}}, rd_row);
    large_variant = 1'b1;
    send(mk(SFEP_OP_ERASE, 22'h0, 64'h0, 4'h0, 16'h0), 1'b0);
    chk("erase options large", 64'h8388898a, erase_log);
    chk("protect after erase large", 64'h0, protect);
    chk("quiet violations", 64'h0, viol);
    // request offered while busy is ignored
    send(mk(SFEP_OP_CORE, 22'h0, 64'h0, 4'h9, 16'h1234), 1'b1);
    chk("frame with refused request", 64'h91234, last_frame);
    repeat (5) @(posedge mclk);
    #1 chk("idle after refusal", 64'h1, req_ready);
    // reset while the row request is still loading the table pointer; the row must stay erased
    req = mk(SFEP_OP_ROW, 22'h20, 64'h0123456789abcdef, 4'h0, 16'h0);
    req_valid = 1'b1;
    @(posedge mclk);
    #1 req_valid = 1'b0;
    repeat (1000) @(posedge mclk);
    #1 resetn = 1'b0;
    #1 chk("outputs in mid reset", 64'h10, {req_ready, req_done, sclk, data_oe, data_o});
    repeat (3) @(posedge mclk);
    #1 resetn = 1'b1;
    send(mk(SFEP_OP_CORE, 22'h0, 64'h0, 4'h0, 16'h0e77), 1'b0);
    chk("frame after reset", 64'h00e77, last_frame);
    rd_addr = 22'h20;
    #1 chk("aborted row", {64{1'b1}}, rd_row);
    print_verdict();
  end
endmodule
